// ---- verilog/port_pin_mux_regs.vh ----
// Summary of operation
// - each bidirectional port bit has its own direction bit, one means output
// - push-pull bits offer a pull-up, enabled only while the bit is an input
// - open-drain port has four bits, pulls low only, has no pull-up
// - analog-shared port has seven input-only bits and no drivers
// - port 2 bits 4-7 are edge interrupts, rising, falling or both selectable
// - port 4 bits 0-5 detect key return activity
// - port 2 bits 0-2 carry serial clock, serial data out, serial data in
// - port 2 bits 4 and 5 feed the two timer count clock inputs
// - port 2 bit 3 outputs timer c output or comparator output
// - port 2 bit 6 outputs wide timer, bit 7 feeds capture trigger
// - analog bit 0 to comparator input, bit 1 to reference, all to converter
// - segments 0-15 dedicated; 20-27 on port 8, 16-19 on port 9; input after reset
// - four common outputs always driven, no port function
// - programming mode returns every non-link pin to its post-reset state
// - pseudo serial programming runs on port 0 or port 4 bits 0-2 by software
`ifndef PORT_PIN_MUX_REGS_VH
`define PORT_PIN_MUX_REGS_VH
`define PPM_P0_DATA 6'h00
`define PPM_P0_DIR 6'h01
`define PPM_P0_PU 6'h02
`define PPM_P2_DATA 6'h04
`define PPM_P2_DIR 6'h05
`define PPM_P2_PU 6'h06
`define PPM_P4_DATA 6'h08
`define PPM_P4_DIR 6'h09
`define PPM_P4_PU 6'h0a
`define PPM_P5_DATA 6'h0c
`define PPM_P5_DIR 6'h0d
`define PPM_P6_DATA 6'h0e
`define PPM_P8_DATA 6'h10
`define PPM_P8_DIR 6'h11
`define PPM_P8_PU 6'h12
`define PPM_P9_DATA 6'h14
`define PPM_P9_DIR 6'h15
`define PPM_P9_PU 6'h16
`define PPM_P2_ALT 6'h18
`define PPM_P23_SEL 6'h19
`define PPM_P8_SEG 6'h1a
`define PPM_P9_SEG 6'h1b
`define PPM_IRQ_RISE 6'h1c
`define PPM_IRQ_FALL 6'h1d
`define PPM_IRQ_STAT 6'h1e
`define PPM_IRQ_MASK 6'h1f
`define PPM_RST_VAL 8'h00
`define PPM_STAT_KEY_BIT 4
`define PPM_LINK_SIO 2'h0
`define PPM_LINK_UART 2'h1
`define PPM_LINK_PSEUDO_P0 2'h2
`define PPM_LINK_PSEUDO_P4 2'h3
`define PPM_PSEUDO_DIR 3'h2
`endif

// ---- verilog/ppm_edge_det.v ----
`timescale 1ns/10ps
module ppm_edge_det (
  input wire ref_clk_i,
  input wire rst_i,
  input wire sig_i,
  input wire rise_en_i,
  input wire fall_en_i,
  output wire edge_o
);
  reg prev_q;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig_i;
    end
  end
  // both enables set gives both-edge detection
  assign edge_o = (rise_en_i & sig_i & ~prev_q) | (fall_en_i & ~sig_i & prev_q);
endmodule

// ---- verilog/port_pin_mux.v ----
`timescale 1ns/10ps
`include "port_pin_mux_regs.vh"
module port_pin_mux (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  output wire irq_o,
  input wire prog_mode_i,
  input wire [1:0] prog_link_sel_i,
  input wire [3:0] port_zero_bits_i,
  output wire [3:0] port_zero_bits_o,
  output wire [3:0] port_zero_bits_oe_o,
  output wire [3:0] port_zero_pu_o,
  input wire [7:0] port_two_bits_i,
  output wire [7:0] port_two_bits_o,
  output wire [7:0] port_two_bits_oe_o,
  output wire [7:0] port_two_pu_o,
  input wire [7:0] port_four_bits_i,
  output wire [7:0] port_four_bits_o,
  output wire [7:0] port_four_bits_oe_o,
  output wire [7:0] port_four_pu_o,
  input wire [3:0] open_drain_port_bits_i,
  output wire [3:0] open_drain_port_bits_o,
  output wire [3:0] open_drain_port_bits_oe_o,
  input wire [6:0] input_only_port_bits_i,
  input wire [7:0] port_eight_bits_i,
  output wire [7:0] port_eight_bits_o,
  output wire [7:0] port_eight_bits_oe_o,
  output wire [7:0] port_eight_pu_o,
  input wire [3:0] port_nine_bits_i,
  output wire [3:0] port_nine_bits_o,
  output wire [3:0] port_nine_bits_oe_o,
  output wire [3:0] port_nine_pu_o,
  input wire sio_clk_i,
  output wire sio_clk_o,
  output wire async_serial_clock_in_o,
  input wire sio_data_out_i,
  output wire sio_data_in_o,
  input wire timer_c_out_i,
  input wire comparator_out_i,
  input wire wide_timer_out_i,
  output wire timer_a_count_in_o,
  output wire timer_b_count_in_o,
  output wire capture_trigger_in_o,
  output wire [3:0] ext_irq_inputs_o,
  output wire [5:0] key_return_lines_o,
  output wire comparator_in_o,
  output wire comparator_ref_in_o,
  output wire [6:0] analog_channels_o,
  input wire [27:0] lcd_segment_i,
  input wire [3:0] lcd_common_i,
  output wire [15:0] segment_outputs_o,
  output wire [3:0] common_outputs_o
);
  reg [3:0] p0_data_q;
  reg [3:0] p0_dir_q;
  reg [3:0] p0_pu_q;
  reg [7:0] p2_data_q;
  reg [7:0] p2_dir_q;
  reg [7:0] p2_pu_q;
  reg [7:0] p4_data_q;
  reg [7:0] p4_dir_q;
  reg [7:0] p4_pu_q;
  reg [3:0] p5_data_q;
  reg [3:0] p5_dir_q;
  reg [7:0] p8_data_q;
  reg [7:0] p8_dir_q;
  reg [7:0] p8_pu_q;
  reg [3:0] p9_data_q;
  reg [3:0] p9_dir_q;
  reg [3:0] p9_pu_q;
  reg [7:0] p2_alt_q;
  reg p23_sel_q;
  reg [7:0] p8_seg_q;
  reg [3:0] p9_seg_q;
  reg [3:0] rise_en_q;
  reg [3:0] fall_en_q;
  reg [4:0] stat_q;
  reg [4:0] stat_d;
  reg [4:0] mask_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg [5:0] key_prev_q;
  wire [3:0] irq_edge;
  wire key_event;
  wire cfg_clr;
  wire pseudo_p0;
  wire pseudo_p4;
  wire ser_link;
  wire [3:0] p0_dir_eff;
  wire [7:0] p2_dir_eff;
  wire [7:0] p2_alt_eff;
  wire [7:0] p4_dir_eff;
  wire [7:0] p2_out;

  // programming mode holds configuration at reset values
  assign cfg_clr = rst_i | prog_mode_i;
  assign pseudo_p0 = prog_mode_i & (prog_link_sel_i == `PPM_LINK_PSEUDO_P0);
  assign pseudo_p4 = prog_mode_i & (prog_link_sel_i == `PPM_LINK_PSEUDO_P4);
  assign ser_link = prog_mode_i & ((prog_link_sel_i == `PPM_LINK_SIO) | (prog_link_sel_i == `PPM_LINK_UART));

  always @(posedge ref_clk_i) begin
    if (cfg_clr) begin
      p0_dir_q <= 4'h0;
      p0_pu_q <= 4'h0;
      p2_data_q <= `PPM_RST_VAL;
      p2_dir_q <= `PPM_RST_VAL;
      p2_pu_q <= `PPM_RST_VAL;
      p4_dir_q <= `PPM_RST_VAL;
      p4_pu_q <= `PPM_RST_VAL;
      p5_data_q <= 4'h0;
      p5_dir_q <= 4'h0;
      p8_data_q <= `PPM_RST_VAL;
      p8_dir_q <= `PPM_RST_VAL;
      p8_pu_q <= `PPM_RST_VAL;
      p9_data_q <= 4'h0;
      p9_dir_q <= 4'h0;
      p9_pu_q <= 4'h0;
      p2_alt_q <= `PPM_RST_VAL;
      p23_sel_q <= 1'b0;
      p8_seg_q <= `PPM_RST_VAL;
      p9_seg_q <= 4'h0;
      rise_en_q <= 4'h0;
      fall_en_q <= 4'h0;
      mask_q <= 5'h00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PPM_P0_DIR: p0_dir_q <= reg_wdata_i[3:0];
        `PPM_P0_PU: p0_pu_q <= reg_wdata_i[3:0];
        `PPM_P2_DATA: p2_data_q <= reg_wdata_i;
        `PPM_P2_DIR: p2_dir_q <= reg_wdata_i;
        `PPM_P2_PU: p2_pu_q <= reg_wdata_i;
        `PPM_P4_DIR: p4_dir_q <= reg_wdata_i;
        `PPM_P4_PU: p4_pu_q <= reg_wdata_i;
        `PPM_P5_DATA: p5_data_q <= reg_wdata_i[3:0];
        `PPM_P5_DIR: p5_dir_q <= reg_wdata_i[3:0];
        `PPM_P8_DATA: p8_data_q <= reg_wdata_i;
        `PPM_P8_DIR: p8_dir_q <= reg_wdata_i;
        `PPM_P8_PU: p8_pu_q <= reg_wdata_i;
        `PPM_P9_DATA: p9_data_q <= reg_wdata_i[3:0];
        `PPM_P9_DIR: p9_dir_q <= reg_wdata_i[3:0];
        `PPM_P9_PU: p9_pu_q <= reg_wdata_i[3:0];
        `PPM_P2_ALT: p2_alt_q <= reg_wdata_i;
        `PPM_P23_SEL: p23_sel_q <= reg_wdata_i[0];
        `PPM_P8_SEG: p8_seg_q <= reg_wdata_i;
        `PPM_P9_SEG: p9_seg_q <= reg_wdata_i[3:0];
        `PPM_IRQ_RISE: rise_en_q <= reg_wdata_i[3:0];
        `PPM_IRQ_FALL: fall_en_q <= reg_wdata_i[3:0];
        `PPM_IRQ_MASK: mask_q <= reg_wdata_i[4:0];
        default: begin
        end
      endcase
    end
  end

  // port 0 and port 4 latches survive programming mode: software drives the pseudo link through them
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      p0_data_q <= 4'h0;
      p4_data_q <= `PPM_RST_VAL;
    end else if (reg_wr_i && reg_addr_i == `PPM_P0_DATA) begin
      p0_data_q <= reg_wdata_i[3:0];
    end else if (reg_wr_i && reg_addr_i == `PPM_P4_DATA) begin
      p4_data_q <= reg_wdata_i;
    end
  end

  // pseudo link: bit 0 clock in, bit 1 data out, bit 2 data in
  assign p0_dir_eff = pseudo_p0 ? {1'b0, `PPM_PSEUDO_DIR} : p0_dir_q;
  assign p4_dir_eff = pseudo_p4 ? {5'h00, `PPM_PSEUDO_DIR} : p4_dir_q;
  // serial link: serial data out driven by the serial unit, clock and data in as inputs
  assign p2_dir_eff = ser_link ? 8'h02 : p2_dir_q;
  assign p2_alt_eff = ser_link ? 8'h02 : p2_alt_q;

  assign port_zero_bits_o = p0_data_q;
  assign port_zero_bits_oe_o = p0_dir_eff;
  assign port_zero_pu_o = p0_pu_q & ~p0_dir_eff;

  // alternate outputs on port 2: 0 serial clock, 1 serial data, 3 timer c/comparator, 6 wide timer
  assign p2_out[0] = p2_alt_eff[0] ? sio_clk_i : p2_data_q[0];
  assign p2_out[1] = p2_alt_eff[1] ? sio_data_out_i : p2_data_q[1];
  assign p2_out[2] = p2_data_q[2];
  assign p2_out[3] = p2_alt_eff[3] ? (p23_sel_q ? comparator_out_i : timer_c_out_i) : p2_data_q[3];
  assign p2_out[5:4] = p2_data_q[5:4];
  assign p2_out[6] = p2_alt_eff[6] ? wide_timer_out_i : p2_data_q[6];
  assign p2_out[7] = p2_data_q[7];
  assign port_two_bits_o = p2_out;
  assign port_two_bits_oe_o = p2_dir_eff;
  assign port_two_pu_o = p2_pu_q & ~p2_dir_eff;

  // input functions see the pin itself, so an output bit loops back its own drive
  assign sio_clk_o = port_two_bits_i[0];
  assign async_serial_clock_in_o = port_two_bits_i[0];
  assign sio_data_in_o = port_two_bits_i[2];
  assign timer_a_count_in_o = port_two_bits_i[4];
  assign timer_b_count_in_o = port_two_bits_i[5];
  assign capture_trigger_in_o = port_two_bits_i[7];
  assign ext_irq_inputs_o = port_two_bits_i[7:4];

  assign port_four_bits_o = p4_data_q;
  assign port_four_bits_oe_o = p4_dir_eff;
  assign port_four_pu_o = p4_pu_q & ~p4_dir_eff;
  assign key_return_lines_o = port_four_bits_i[5:0];

  // open drain: only a low is ever driven, a high latch releases the pin
  assign open_drain_port_bits_o = 4'h0;
  assign open_drain_port_bits_oe_o = p5_dir_q & ~p5_data_q;

  assign analog_channels_o = input_only_port_bits_i;
  assign comparator_in_o = input_only_port_bits_i[0];
  assign comparator_ref_in_o = input_only_port_bits_i[1];

  // segment enable takes the pin over from the port regardless of direction
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_p8
      assign port_eight_bits_o[gi] = p8_seg_q[gi] ? lcd_segment_i[27 - gi] : p8_data_q[gi];
      assign port_eight_bits_oe_o[gi] = p8_seg_q[gi] | p8_dir_q[gi];
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_p9
      assign port_nine_bits_o[gi] = p9_seg_q[gi] ? lcd_segment_i[19 - gi] : p9_data_q[gi];
      assign port_nine_bits_oe_o[gi] = p9_seg_q[gi] | p9_dir_q[gi];
    end
  endgenerate
  assign port_eight_pu_o = p8_pu_q & ~port_eight_bits_oe_o;
  assign port_nine_pu_o = p9_pu_q & ~port_nine_bits_oe_o;
  assign segment_outputs_o = lcd_segment_i[15:0];
  assign common_outputs_o = lcd_common_i;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
      ppm_edge_det u_edge (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .sig_i(port_two_bits_i[4 + gi]),
        .rise_en_i(rise_en_q[gi]),
        .fall_en_i(fall_en_q[gi]),
        .edge_o(irq_edge[gi])
      );
    end
  endgenerate

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      key_prev_q <= 6'h3f;
    end else begin
      key_prev_q <= port_four_bits_i[5:0];
    end
  end
  // a key press pulls a return line low; output bits are ignored
  assign key_event = |(key_prev_q & ~port_four_bits_i[5:0] & ~p4_dir_eff[5:0]);

  always @* begin
    stat_d = stat_q;
    if (reg_wr_i && reg_addr_i == `PPM_IRQ_STAT) begin
      stat_d = stat_q & ~reg_wdata_i[4:0];
    end
    // set wins over a clear in the same cycle
    stat_d = stat_d | {key_event, irq_edge};
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      stat_q <= 5'h00;
    end else begin
      stat_q <= stat_d;
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // data reads return the pin for inputs and the latch for outputs, port 2 alternate outputs give their source; port 5 always reads the pin
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `PPM_P0_DATA: rdata_d = {4'h0, (p0_dir_eff & p0_data_q) | (~p0_dir_eff & port_zero_bits_i)};
      `PPM_P0_DIR: rdata_d = {4'h0, p0_dir_q};
      `PPM_P0_PU: rdata_d = {4'h0, p0_pu_q};
      `PPM_P2_DATA: rdata_d = (p2_dir_eff & p2_out) | (~p2_dir_eff & port_two_bits_i);
      `PPM_P2_DIR: rdata_d = p2_dir_q;
      `PPM_P2_PU: rdata_d = p2_pu_q;
      `PPM_P4_DATA: rdata_d = (p4_dir_eff & p4_data_q) | (~p4_dir_eff & port_four_bits_i);
      `PPM_P4_DIR: rdata_d = p4_dir_q;
      `PPM_P4_PU: rdata_d = p4_pu_q;
      `PPM_P5_DATA: rdata_d = {4'h0, open_drain_port_bits_i};
      `PPM_P5_DIR: rdata_d = {4'h0, p5_dir_q};
      `PPM_P6_DATA: rdata_d = {1'b0, input_only_port_bits_i};
      `PPM_P8_DATA: rdata_d = (p8_dir_q & p8_data_q) | (~p8_dir_q & port_eight_bits_i);
      `PPM_P8_DIR: rdata_d = p8_dir_q;
      `PPM_P8_PU: rdata_d = p8_pu_q;
      `PPM_P9_DATA: rdata_d = {4'h0, (p9_dir_q & p9_data_q) | (~p9_dir_q & port_nine_bits_i)};
      `PPM_P9_DIR: rdata_d = {4'h0, p9_dir_q};
      `PPM_P9_PU: rdata_d = {4'h0, p9_pu_q};
      `PPM_P2_ALT: rdata_d = p2_alt_q;
      `PPM_P23_SEL: rdata_d = {7'h00, p23_sel_q};
      `PPM_P8_SEG: rdata_d = p8_seg_q;
      `PPM_P9_SEG: rdata_d = {4'h0, p9_seg_q};
      `PPM_IRQ_RISE: rdata_d = {4'h0, rise_en_q};
      `PPM_IRQ_FALL: rdata_d = {4'h0, fall_en_q};
      `PPM_IRQ_STAT: rdata_d = {3'h0, stat_q};
      `PPM_IRQ_MASK: rdata_d = {3'h0, mask_q};
      default: rdata_d = 8'h00;
    endcase
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata_o = rdata_q;
endmodule

// ---- tb/ppm_chk.sv ----
`timescale 1ns/10ps
module ppm_chk (
  input wire ref_clk_i,
  input wire rst_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire irq_o,
  input wire prog_mode_i,
  input wire [1:0] prog_link_sel_i,
  input wire [3:0] port_zero_bits_oe_o,
  input wire [7:0] port_two_bits_i,
  input wire [7:0] port_two_bits_oe_o,
  input wire [7:0] port_two_pu_o,
  input wire [7:0] port_four_bits_i,
  input wire [3:0] open_drain_port_bits_o,
  input wire [6:0] input_only_port_bits_i,
  input wire [3:0] ext_irq_inputs_o,
  input wire timer_b_count_in_o,
  input wire capture_trigger_in_o,
  input wire [5:0] key_return_lines_o,
  input wire comparator_ref_in_o,
  input wire [6:0] analog_channels_o,
  input wire [27:0] lcd_segment_i,
  input wire [15:0] segment_outputs_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  rst_clear_a: assert property ($fell(rst_i) |-> !irq_o && reg_rdata_o == 8'h00 &&
    (port_two_bits_oe_o | port_two_pu_o) == 8'h00) else $error("state not clear after reset");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data outside read");
  pu_input_a: assert property ((port_two_pu_o & port_two_bits_oe_o) == 8'h00) else $error("pull-up on output");
  od_low_a: assert property (open_drain_port_bits_o == 4'h0) else $error("open drain drives high");
  seg_fixed_a: assert property (segment_outputs_o == lcd_segment_i[15:0]) else $error("segment mismatch");
  in_route_a: assert property (ext_irq_inputs_o == port_two_bits_i[7:4] &&
    timer_b_count_in_o == port_two_bits_i[5] && capture_trigger_in_o == port_two_bits_i[7]) else $error("input route");
  key_route_a: assert property (key_return_lines_o == port_four_bits_i[5:0]) else $error("key route");
  analog_route_a: assert property (analog_channels_o == input_only_port_bits_i &&
    comparator_ref_in_o == input_only_port_bits_i[1]) else $error("analog route");
  // one settled cycle allowed, the override may be registered
  prog_link_a: assert property (prog_mode_i && $past(prog_mode_i) && prog_link_sel_i == 2'h2 &&
    $stable(prog_link_sel_i) |-> port_zero_bits_oe_o == 4'h2 && port_two_bits_oe_o == 8'h00) else $error("prog link");
endmodule
bind port_pin_mux ppm_chk u_ppm_chk (.*);

// ---- tb/ppm_board.sv ----
`timescale 1ns/10ps
module ppm_board (
  input wire [7:0] drv_i,
  input wire [7:0] oe_i,
  input wire [7:0] pu_i,
  input wire [7:0] ext_i,
  output wire [7:0] pin_o
);
  // an undriven pin without pull-up follows the board source, never a held value
  assign pin_o = (oe_i & drv_i) | (~oe_i & (pu_i | ext_i));
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
  logic ref_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, prog_mode_i = 0, irq_o;
  logic sio_clk_i = 0, sio_data_out_i = 0, timer_c_out_i = 0, comparator_out_i = 0, wide_timer_out_i = 0;
  logic sio_clk_o, async_serial_clock_in_o, sio_data_in_o, timer_a_count_in_o, timer_b_count_in_o;
  logic capture_trigger_in_o, comparator_in_o, comparator_ref_in_o;
  logic [1:0] prog_link_sel_i = 0;
  logic [5:0] reg_addr_i = 0, key_return_lines_o, b;
  logic [6:0] input_only_port_bits_i = 0, analog_channels_o;
  logic [3:0] port_zero_bits_i = 0, port_nine_bits_i = 0, lcd_common_i = 0, open_drain_port_bits_i;
  logic [3:0] port_zero_bits_o, port_zero_bits_oe_o, port_zero_pu_o, port_nine_bits_o, port_nine_bits_oe_o;
  logic [3:0] port_nine_pu_o, open_drain_port_bits_o, open_drain_port_bits_oe_o, ext_irq_inputs_o;
  logic [3:0] common_outputs_o;
  logic [7:0] reg_wdata_i = 0, port_eight_bits_i = 0, p2_ext = 0, p4_ext = 8'hff, reg_rdata_o, d, m, v;
  logic [7:0] port_two_bits_i, port_two_bits_o, port_two_bits_oe_o, port_two_pu_o, port_four_bits_i;
  logic [7:0] port_four_bits_o, port_four_bits_oe_o, port_four_pu_o, port_eight_bits_o, port_eight_bits_oe_o;
  logic [7:0] port_eight_pu_o;
  logic [15:0] segment_outputs_o;
  logic [27:0] lcd_segment_i = 0;
  integer seed = 32'he1ea1b5d, n_mismatch = 0, checks_done = 0, i;
  port_pin_mux u_port_pin_mux (.*);
  ppm_board u_board_two (.drv_i(port_two_bits_o), .oe_i(port_two_bits_oe_o), .pu_i(port_two_pu_o),
    .ext_i(p2_ext), .pin_o(port_two_bits_i));
  ppm_board u_board_four (.drv_i(port_four_bits_o), .oe_i(port_four_bits_oe_o), .pu_i(port_four_pu_o),
    .ext_i(p4_ext), .pin_o(port_four_bits_i));
  assign open_drain_port_bits_i = ~open_drain_port_bits_oe_o;
  always #4 ref_clk_i = ~ref_clk_i;
  task automatic wr(input logic [5:0] a, input logic [7:0] x);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= x;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("reg_rdata_o", e, reg_rdata_o)
  endtask
  task automatic rnd;
    @(posedge ref_clk_i);
    {port_zero_bits_i, port_nine_bits_i, port_eight_bits_i, input_only_port_bits_i} <= $random(seed);
    {sio_clk_i, sio_data_out_i, timer_c_out_i, comparator_out_i, wide_timer_out_i, lcd_common_i} <= $random(seed);
    lcd_segment_i <= $random(seed);
    #1;
  endtask
  task automatic close_out;
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 32; i++) if (!(i inside {0, 4, 8, 12, 14, 16, 20})) rd(i[5:0], 8'h00);
    `CHK("oe_pu", 8'h00, port_two_bits_oe_o | port_four_bits_oe_o | port_two_pu_o | port_eight_bits_oe_o)
    for (i = 0; i < 8; i++) begin
      b = i[0] ? 6'h08 : 6'h04;
      rnd;
      p2_ext = $random(seed);
      p4_ext = $random(seed);
      d = $random(seed);
      m = $random(seed);
      v = $random(seed);
      wr(b | 6'h1, m);
      wr(b, d);
      wr(b | 6'h2, v);
      rd(b, (m & d) | (~m & (v | (i[0] ? p4_ext : p2_ext))));
      `CHK("oe", m, i[0] ? port_four_bits_oe_o : port_two_bits_oe_o)
      `CHK("pu", v & ~m, i[0] ? port_four_pu_o : port_two_pu_o)
    end
    wr(6'h06, 8'h00);
    wr(6'h0a, 8'h00);
    wr(6'h0d, 8'h0f);
    wr(6'h0c, 8'h05);
    `CHK("od_oe", 4'ha, open_drain_port_bits_oe_o)
    rd(6'h0c, 8'h05);
    rnd;
    wr(6'h0e, 8'hff);
    rd(6'h0e, {1'b0, input_only_port_bits_i});
    `CHK("cmp_in", input_only_port_bits_i[0], comparator_in_o)
    wr(6'h05, 8'hff);
    wr(6'h04, 8'h00);
    wr(6'h18, 8'h4b);
    for (i = 0; i < 4; i++) begin
      wr(6'h19, {7'h00, i[0]});
      rnd;
      `CHK("p2_alt", {1'b0, wide_timer_out_i, 2'b00, i[0] ? comparator_out_i : timer_c_out_i, 1'b0,
        sio_data_out_i, sio_clk_i}, port_two_bits_o)
      `CHK("p2_in", {sio_clk_i, sio_clk_i, 1'b0, 1'b0}, {sio_clk_o, async_serial_clock_in_o, sio_data_in_o, timer_a_count_in_o})
    end
    wr(6'h18, 8'h00);
    wr(6'h05, 8'h00);
    wr(6'h09, 8'h00);
    wr(6'h1a, 8'hff);
    wr(6'h1b, 8'h0f);
    rnd;
    for (i = 0; i < 8; i++) begin
      `CHK("p8_seg", lcd_segment_i[27 - i], port_eight_bits_o[i])
      if (i < 4) `CHK("p9_seg", lcd_segment_i[19 - i], port_nine_bits_o[i])
    end
    `CHK("seg_oe", 12'hfff, {port_eight_bits_oe_o, port_nine_bits_oe_o})
    `CHK("com", lcd_common_i, common_outputs_o)
    @(posedge ref_clk_i);
    p2_ext <= 8'h00;
    p4_ext <= 8'hff;
    wr(6'h1c, 8'h05);
    wr(6'h1d, 8'h06);
    wr(6'h1f, 8'h1f);
    wr(6'h1e, 8'hff);
    // rise then fall on each input; bit 3 has no edge enabled and must stay quiet
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk_i);
      p2_ext[4 + i / 2] <= ~i[0];
      repeat (2) @(posedge ref_clk_i);
      d = ((i[0] ? 8'h06 : 8'h05) >> (i / 2)) & 8'h01;
      rd(6'h1e, d << (i / 2));
      `CHK("irq_o", |d, irq_o)
      wr(6'h1e, 8'hff);
    end
    wr(6'h1f, 8'h10);
    @(posedge ref_clk_i);
    p4_ext[0] <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rd(6'h1e, 8'h10);
    `CHK("irq_key", 1'b1, irq_o)
    wr(6'h1f, 8'h00);
    `CHK("irq_masked", 1'b0, irq_o)
    wr(6'h05, 8'hff);
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      prog_mode_i <= 1'b1;
      prog_link_sel_i <= i[1:0];
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK("prog_oe", i < 2 ? 20'h00200 : (i == 2 ? 20'h20000 : 20'h00002),
        {port_zero_bits_oe_o, port_two_bits_oe_o, port_four_bits_oe_o})
    end
    @(posedge ref_clk_i);
    prog_mode_i <= 1'b0;
    rd(6'h05, 8'h00);
    close_out;
  end
endmodule
